// ---- hdl/ptmr_periodic_timer.sv ----
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module ptmr_periodic_timer
	import ptmr_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// external tick pin
	input wire logic ext_tick_pin_i,
	// waveform pin
	output logic wave_out_pin_o,
	output logic wave_out_pin_oe_n_o,
	// axi4-lite write address
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ************************************
	// registers
	// ************************************
	logic [7:0] timer_control_0;
	logic [7:0] timer_control_1;
	logic [9:0] match_a_value;
	logic [9:0] match_p_value;
	logic [9:0] count;
	logic match_a_flag;
	logic match_p_flag;
	logic pin_level;
	logic run_prev;
	logic [1:0] ext_sync;
	logic ext_prev;
	logic [5:0] div_cnt;
	logic [10:0] sub_cnt;
	logic aw_held;
	logic w_held;
	logic [31:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire logic count_hold = timer_control_0[C0_HOLD];
	wire logic [2:0] tick_source_sel = timer_control_0[C0_SRC_HI:C0_SRC_LO];
	wire logic run_ctl = timer_control_0[C0_RUN];
	wire logic [1:0] op_mode_sel = timer_control_1[C1_MODE_HI:C1_MODE_LO];
	wire logic [1:0] pin_action_sel = timer_control_1[C1_ACT_HI:C1_ACT_LO];
	wire logic pin_start_level = timer_control_1[C1_START];
	wire logic pin_invert = timer_control_1[C1_INV];
	wire logic clear_source_sel = timer_control_1[C1_CLR];
	wire logic run_rise = run_ctl & ~run_prev;
	wire logic is_pwm = (op_mode_sel == MODE_PWM);
	wire logic is_cmp = (op_mode_sel == MODE_CMP);
	wire logic is_tmr = (op_mode_sel == MODE_TMR);
	// ************************************
	// tick generation
	// ************************************
	// pin passes two flops before the edge detector looks at it
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ext_sync <= 2'b00;
			ext_prev <= 1'b0;
		end else begin
			ext_sync <= {ext_sync[0], ext_tick_pin_i};
			ext_prev <= ext_sync[1];
		end
	end
	// div_cnt serves the /4, /16 and /64 rates, sub_cnt the sub clock rate; high clock taken as core clock
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			div_cnt <= 6'd0;
			sub_cnt <= 11'd0;
		end else begin
			div_cnt <= div_cnt + 6'd1;
			sub_cnt <= (sub_cnt == SUB_LAST) ? 11'd0 : sub_cnt + 11'd1;
		end
	end
	logic tick;
	always_comb begin
		unique case (tick_source_sel)
			SRC_CORE_DIV4: tick = (div_cnt[1:0] == DIV4_LAST[1:0]);
			SRC_CORE: tick = 1'b1;
			SRC_HIGH_DIV16: tick = (div_cnt[3:0] == DIV16_LAST[3:0]);
			SRC_HIGH_DIV64: tick = (div_cnt == DIV64_LAST);
			SRC_SUB_A, SRC_SUB_B: tick = (sub_cnt == SUB_LAST);
			SRC_EXT_RISE: tick = ext_sync[1] & ~ext_prev;
			SRC_EXT_FALL: tick = ~ext_sync[1] & ext_prev;
		endcase
	end

	// ************************************
	// comparators and counter
	// ************************************
	wire logic step = run_ctl & ~count_hold & tick;
	wire logic hit_a = step & (count == match_a_value);
	wire logic hit_p = step & (count == ((match_p_value == 10'd0) ? CNT_MAX : match_p_value));
	wire logic hit_ovf = step & (count == CNT_MAX);
	logic clr_now;
	always_comb begin
		if (is_pwm) begin
			clr_now = hit_p;
		end else if (clear_source_sel) begin
			clr_now = hit_a & (match_a_value != 10'd0);
		end else begin
			clr_now = hit_p | (hit_ovf & (match_p_value == 10'd0));
		end
	end
	// single pulse: match A drops the run bit
	wire logic single_end = is_pwm & (pin_action_sel == PACT_SINGLE) & hit_a;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			count <= 10'd0;
		end else if (run_rise) begin
			count <= 10'd0;
		end else if (clr_now) begin
			count <= 10'd0;
		end else if (step) begin
			count <= count + 10'd1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			run_prev <= 1'b0;
		end else begin
			run_prev <= run_ctl;
		end
	end

	// ************************************
	// event flags
	// ************************************
	// hit sets win over a software clear in the same cycle
	logic clr_fa;
	logic clr_fp;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			match_a_flag <= 1'b0;
			match_p_flag <= 1'b0;
		end else begin
			if (hit_a & ~(is_cmp | is_tmr) | hit_a & (match_a_value != 10'd0)) begin
				match_a_flag <= 1'b1;
			end else if (clr_fa) begin
				match_a_flag <= 1'b0;
			end
			if (hit_p & (is_pwm | ~clear_source_sel)) begin
				match_p_flag <= 1'b1;
			end else if (clr_fp) begin
				match_p_flag <= 1'b0;
			end
		end
	end

	// ************************************
	// waveform pin
	// ************************************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pin_level <= 1'b0;
		end else if (run_rise) begin
			pin_level <= pin_start_level;
		end else if (is_cmp & hit_a & (match_a_value != 10'd0)) begin
			unique case (pin_action_sel)
				ACT_NONE: pin_level <= pin_level;
				ACT_LOW: pin_level <= 1'b0;
				ACT_HIGH: pin_level <= 1'b1;
				ACT_TOGGLE: pin_level <= ~pin_level;
			endcase
		end else if (is_pwm) begin
			unique case (pin_action_sel)
				PACT_INACT: pin_level <= ~pin_start_level;
				PACT_ACT: pin_level <= pin_start_level;
				PACT_PWM: begin
					if (hit_a) begin
						pin_level <= ~pin_start_level;
					end else if (hit_p | run_rise) begin
						pin_level <= pin_start_level;
					end
				end
				PACT_SINGLE: begin
					if (hit_a | ~run_ctl) begin
						pin_level <= ~pin_start_level;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wave_out_pin_o <= 1'b0;
			wave_out_pin_oe_n_o <= 1'b1;
		end else begin
			wave_out_pin_o <= pin_level ^ pin_invert;
			wave_out_pin_oe_n_o <= is_tmr | (op_mode_sel == 2'b01);
		end
	end

	// ************************************
	// axi4-lite write side
	// ************************************
	wire logic do_write = aw_held & w_held & ~s_axi_bvalid;
	wire logic [5:0] wa = aw_addr[5:0];
	wire logic wa_ok = (aw_addr[31:6] == 26'd0) & (aw_addr[5] == 1'b0 | aw_addr[4:0] == 5'h00);
	assign clr_fa = do_write & w_strb[0] & (aw_addr[31:6] == 26'd0) & (wa == ADDR_FLAGS) & w_data[0];
	assign clr_fp = do_write & w_strb[0] & (aw_addr[31:6] == 26'd0) & (wa == ADDR_FLAGS) & w_data[1];

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 32'h0000_0000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wa_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			timer_control_0 <= RST_BYTE;
			timer_control_1 <= RST_BYTE;
			match_a_value <= 10'd0;
			match_p_value <= 10'd0;
		end else begin
			if (single_end) begin
				timer_control_0[C0_RUN] <= 1'b0;
			end
			if (do_write & w_strb[0] & ~aw_addr[5] & (aw_addr[31:6] == 26'd0)) begin
				unique case (wa)
					ADDR_CTRL0: timer_control_0 <= w_data[7:0] & C0_MASK;
					ADDR_CTRL1: timer_control_1 <= w_data[7:0];
					ADDR_MA_LO: match_a_value[7:0] <= w_data[7:0];
					ADDR_MA_HI: match_a_value[9:8] <= w_data[1:0];
					ADDR_MP_LO: match_p_value[7:0] <= w_data[7:0];
					ADDR_MP_HI: match_p_value[9:8] <= w_data[1:0];
					default: ;
				endcase
			end
		end
	end

	// ************************************
	// axi4-lite read side
	// ************************************
	function automatic logic [7:0] ptmr_rd(input logic [5:0] a, input logic [7:0] c0, input logic [7:0] c1,
		input logic [9:0] cn, input logic [9:0] ma, input logic [9:0] mp, input logic [1:0] fl);
		case (a)
			ADDR_CTRL0: ptmr_rd = c0 & C0_MASK;
			ADDR_CTRL1: ptmr_rd = c1;
			ADDR_CNT_LO: ptmr_rd = cn[7:0];
			ADDR_CNT_HI: ptmr_rd = {6'd0, cn[9:8]};
			ADDR_MA_LO: ptmr_rd = ma[7:0];
			ADDR_MA_HI: ptmr_rd = {6'd0, ma[9:8]};
			ADDR_MP_LO: ptmr_rd = mp[7:0];
			ADDR_MP_HI: ptmr_rd = {6'd0, mp[9:8]};
			ADDR_FLAGS: ptmr_rd = {6'd0, fl};
			default: ptmr_rd = 8'h00;
		endcase
	endfunction : ptmr_rd

	wire logic ra_ok = (s_axi_araddr[31:6] == 26'd0) & (s_axi_araddr[5] == 1'b0 | s_axi_araddr[4:0] == 5'h00);
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
			s_axi_arready <= 1'b1;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_arready <= 1'b0;
			s_axi_rdata <= {24'h000000, ptmr_rd(s_axi_araddr[5:0], timer_control_0, timer_control_1, count,
				match_a_value, match_p_value, {match_p_flag, match_a_flag})};
			s_axi_rresp <= ra_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ************************************
	// checks
	// ************************************
	run_clears_cnt_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_rise |=> (count == 10'd0)) else $error("count not cleared on run start");
	hold_keeps_cnt_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(count_hold & run_prev & run_ctl & ~single_end) |=> $stable(count)) else $error("count moved while held");
	off_keeps_cnt_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(~run_ctl & ~run_prev) |=> $stable(count)) else $error("count moved while off");
	start_level_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(run_rise & ~is_tmr) |=> (pin_level == $past(pin_start_level))) else $error("pin not at start level");
	clr_a_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(hit_a & clear_source_sel & ~is_pwm & ~run_rise & (match_a_value != 10'd0)) |=> (count == 10'd0))
		else $error("match A did not clear");
	step_inc_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(step & ~clr_now & ~run_rise) |=> (count == $past(count) + 10'd1)) else $error("count did not step");
	timer_undriven_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		is_tmr |=> wave_out_pin_oe_n_o) else $error("pin driven in timer mode");
	ctrl0_low_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		timer_control_0[2:0] == 3'b000) else $error("control 0 low bits set");
	toggle_cmp_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(is_cmp & hit_a & (match_a_value != 10'd0) & ~run_rise & (pin_action_sel == ACT_TOGGLE))
		|=> (pin_level != $past(pin_level))) else $error("toggle missed");
endmodule : ptmr_periodic_timer

// ---- hdl/ptmr_pkg.sv ----
package ptmr_pkg;
	// ************************************
	// register byte addresses
	// ************************************
	localparam logic [5:0] ADDR_CTRL0 = 6'h00;
	localparam logic [5:0] ADDR_CTRL1 = 6'h04;
	localparam logic [5:0] ADDR_CNT_LO = 6'h08;
	localparam logic [5:0] ADDR_CNT_HI = 6'h0c;
	localparam logic [5:0] ADDR_MA_LO = 6'h10;
	localparam logic [5:0] ADDR_MA_HI = 6'h14;
	localparam logic [5:0] ADDR_MP_LO = 6'h18;
	localparam logic [5:0] ADDR_MP_HI = 6'h1c;
	localparam logic [5:0] ADDR_FLAGS = 6'h20;
	// ************************************
	// field positions
	// ************************************
	localparam int C0_HOLD = 7;
	localparam int C0_SRC_HI = 6;
	localparam int C0_SRC_LO = 4;
	localparam int C0_RUN = 3;
	localparam int C1_MODE_HI = 7;
	localparam int C1_MODE_LO = 6;
	localparam int C1_ACT_HI = 5;
	localparam int C1_ACT_LO = 4;
	localparam int C1_START = 3;
	localparam int C1_INV = 2;
	localparam int C1_CLR = 0;
	localparam logic [7:0] C0_MASK = 8'hf8;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [9:0] CNT_MAX = 10'h3ff;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// ************************************
	// mode and action codes
	// ************************************
	localparam logic [1:0] MODE_CMP = 2'b00;
	localparam logic [1:0] MODE_PWM = 2'b10;
	localparam logic [1:0] MODE_TMR = 2'b11;
	localparam logic [1:0] ACT_NONE = 2'b00;
	localparam logic [1:0] ACT_LOW = 2'b01;
	localparam logic [1:0] ACT_HIGH = 2'b10;
	localparam logic [1:0] ACT_TOGGLE = 2'b11;
	localparam logic [1:0] PACT_INACT = 2'b00;
	localparam logic [1:0] PACT_ACT = 2'b01;
	localparam logic [1:0] PACT_PWM = 2'b10;
	localparam logic [1:0] PACT_SINGLE = 2'b11;
	// ************************************
	// tick sources and divider counts
	// ************************************
	localparam logic [2:0] SRC_CORE_DIV4 = 3'b000;
	localparam logic [2:0] SRC_CORE = 3'b001;
	localparam logic [2:0] SRC_HIGH_DIV16 = 3'b010;
	localparam logic [2:0] SRC_HIGH_DIV64 = 3'b011;
	localparam logic [2:0] SRC_SUB_A = 3'b100;
	localparam logic [2:0] SRC_SUB_B = 3'b101;
	localparam logic [2:0] SRC_EXT_RISE = 3'b110;
	localparam logic [2:0] SRC_EXT_FALL = 3'b111;
	localparam logic [5:0] DIV4_LAST = 6'd3;
	localparam logic [5:0] DIV16_LAST = 6'd15;
	localparam logic [5:0] DIV64_LAST = 6'd63;
	localparam int CORE_CLK_HZ = 50000000;
	localparam int SUB_CLK_HZ = 32768;
	localparam int SUB_DIV = CORE_CLK_HZ / SUB_CLK_HZ;
	localparam logic [10:0] SUB_LAST = 11'(SUB_DIV - 1);
endpackage : ptmr_pkg

// ---- tb/ptmr_pin_model.sv ----
`timescale 1ns/1ps
module ptmr_pin_model (
	// clock
	input wire logic clk_i,
	// tick pin driven into the timer
	output logic ext_tick_pin_o,
	// waveform pin from the timer
	input wire logic wave_out_pin_i,
	input wire logic wave_out_pin_oe_n_i,
	// level seen on the board
	output logic pad_o
);
	// ************************************
	// tick pulses, four cycles each level
	// ************************************
	initial ext_tick_pin_o = 1'b0;
	task automatic pulse(input int n);
		repeat (n) begin
			repeat (4) @(posedge clk_i);
			ext_tick_pin_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			ext_tick_pin_o <= 1'b0;
		end
	endtask : pulse
	// ************************************
	// pad with pull-down
	// ************************************
	// a released pin must not show its last driven level
	assign pad_o = wave_out_pin_oe_n_i ? 1'b0 : wave_out_pin_i;
endmodule : ptmr_pin_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
	import ptmr_pkg::*;
;
	// ************************************
	// signals
	// ************************************
	localparam logic [7:0] C0 = 8'(ADDR_CTRL0), C1 = 8'(ADDR_CTRL1), ML = 8'(ADDR_MA_LO);
	localparam logic [7:0] PL = 8'(ADDR_MP_LO), FL = 8'(ADDR_FLAGS);
	logic clk_i, rst_n_i, ext_pin, pin, oe_n, pad;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp;
	int bad_count, checked;
	ptmr_periodic_timer i_ptmr_periodic_timer (.clk_i(clk_i), .rst_n_i(rst_n_i), .ext_tick_pin_i(ext_pin),
		.wave_out_pin_o(pin), .wave_out_pin_oe_n_o(oe_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	ptmr_pin_model i_ptmr_pin_model (.clk_i(clk_i), .ext_tick_pin_o(ext_pin), .wave_out_pin_i(pin),
		.wave_out_pin_oe_n_i(oe_n), .pad_o(pad));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// ************************************
	// compare and report
	// ************************************
	task automatic chk(input string s, input logic [9:0] e, input logic [9:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic chk_rng(input string s, input logic [9:0] lo, input logic [9:0] hi, input logic [9:0] g);
		checked++;
		if ($isunknown(g) || g < lo || g > hi) begin
			bad_count++;
			$display("Error %s expected %h to %h seen %h", s, lo, hi, g);
		end
	endtask : chk_rng
	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report
	// ************************************
	// bus tasks, bready and rready stay high
	// ************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rsp = RESP_OKAY);
		int n;
		n = 0;
		awaddr <= {24'h0, a};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		chk("bresp", {7'h0, bvalid, bresp}, {7'h0, 1'b1, rsp});
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d, input logic [1:0] rsp = RESP_OKAY);
		int n;
		n = 0;
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		d = rdata[7:0];
		chk("rresp", {7'h0, rvalid, rresp}, {7'h0, 1'b1, rsp});
	endtask : rd
	task automatic rdc(output logic [9:0] c);
		logic [7:0] lo, hi;
		rd(8'(ADDR_CNT_LO), lo);
		rd(8'(ADDR_CNT_HI), hi);
		chk("count high top", 10'(hi[7:2]), 10'h0);
		c = {hi[1:0], lo};
	endtask : rdc
	// ************************************
	// watchdog
	// ************************************
	initial begin
		repeat (40000) @(posedge clk_i);
		bad_count++;
		final_report();
	end
	// ************************************
	// tests
	// ************************************
	initial begin
		logic [7:0] d;
		logic [9:0] a, b;
		logic lv;
		int w;
		int dv[6];
		rst_n_i = 1'b0;
		dv = '{4, 1, 16, 64, SUB_DIV, SUB_DIV};
		awaddr = '0;
		wdata = '0;
		araddr = '0;
		wstrb = 4'hf;
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		bready = 1'b1;
		rready = 1'b1;
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		for (int i = 0; i < 9; i++) begin
			rd(8'(i * 4), d);
			chk("reset value", 10'(d), 10'h0);
		end
		wr(8'h24, 8'hff, RESP_SLVERR);
		rd(8'h24, d, RESP_SLVERR);
		wr(C0, 8'hf7);
		rd(C0, d);
		chk("control 0", 10'(d), 10'h0f0);
		wr(C0, 8'h00);
		wr(C1, 8'hfd);
		rd(C1, d);
		chk("control 1", 10'(d), 10'h0fd);
		wr(C1, 8'h00);
		for (int p = 0; p < 2; p++) begin
			wr(ML + 8'(p * 8), 8'ha5);
			wr(ML + 8'(p * 8 + 4), 8'hff);
			rd(ML + 8'(p * 8), d);
			chk("match low", 10'(d), 10'h0a5);
			rd(ML + 8'(p * 8 + 4), d);
			chk("match high", 10'(d), 10'h003);
			wr(ML + 8'(p * 8), 8'h00);
			wr(ML + 8'(p * 8 + 4), 8'h00);
		end
		$display("test registers done");
		wr(C0, 8'h18);
		rdc(a);
		rdc(b);
		chk_rng("count runs", a + 10'd1, 10'h3ff, b);
		wr(C0, 8'h98);
		rdc(a);
		rdc(b);
		chk("count held", a, b);
		chk_rng("hold keeps value", 10'd8, 10'h3ff, a);
		wr(C0, 8'h18);
		rdc(b);
		chk_rng("count resumes", a + 10'd1, a + 10'd40, b);
		repeat (40) @(posedge clk_i);
		wr(C0, 8'h10);
		rdc(a);
		repeat (20) @(posedge clk_i);
		rdc(b);
		chk("count stopped", a, b);
		wr(C0, 8'h18);
		rdc(b);
		chk_rng("count restarts", 10'd0, 10'd20, b);
		repeat (1100) @(posedge clk_i);
		rdc(a);
		chk_rng("count wraps", 10'd1, 10'h0ff, a);
		$display("test counting done");
		for (int s = 0; s < 6; s++) begin
			wr(C0, 8'h00);
			wr(C0, {1'b0, 3'(s), 4'h8});
			rdc(a);
			repeat (200) @(posedge clk_i);
			rdc(b);
			w = 200 / dv[s];
			chk_rng("tick rate", a + 10'(w * 9 / 10), a + 10'(w + 10), b);
		end
		for (int s = 6; s < 8; s++) begin
			wr(C0, 8'h00);
			wr(C0, {1'b0, 3'(s), 4'h8});
			i_ptmr_pin_model.pulse(5);
			repeat (10) @(posedge clk_i);
			rdc(a);
			chk("pin ticks", 10'd5, a);
		end
		$display("test tick sources done");
		wr(ML, 8'h40);
		for (int k = 0; k < 16; k++) begin
			wr(C0, 8'h00);
			wr(C1, {2'b00, 2'(k >> 2), k[1], k[0], 2'b00});
			wr(C0, 8'h18);
			repeat (4) @(posedge clk_i);
			chk("pin start", {8'h0, oe_n, pad}, {9'h0, k[1] ^ k[0]});
			repeat (100) @(posedge clk_i);
			case (2'(k >> 2))
				ACT_NONE: lv = k[1];
				ACT_LOW: lv = 1'b0;
				ACT_HIGH: lv = 1'b1;
				default: lv = ~k[1];
			endcase
			chk("pin after match", {9'h0, pad}, {9'h0, lv ^ k[0]});
		end
		for (int k = 0; k < 2; k++) begin
			wr(C0, 8'h00);
			wr(C1, {2'b10, 1'b0, k[0], 4'h8});
			wr(C0, 8'h18);
			repeat (4) @(posedge clk_i);
			chk("forced level", {8'h0, oe_n, pad}, {9'h0, k[0]});
		end
		wr(C0, 8'h00);
		wr(C1, 8'hc8);
		wr(C0, 8'h18);
		repeat (4) @(posedge clk_i);
		chk("timer pin released", {8'h0, oe_n, pad}, 10'h2);
		$display("test pin done");
		wr(ML, 8'h08);
		wr(PL, 8'h10);
		for (int c = 0; c < 2; c++) begin
			wr(C0, 8'h00);
			wr(C1, {7'h0, c[0]});
			wr(FL, 8'h03);
			wr(C0, 8'h18);
			repeat (60) @(posedge clk_i);
			rd(FL, d);
			chk("flags", 10'(d), c[0] ? 10'h1 : 10'h3);
			rdc(a);
			chk_rng("clear point", 10'd0, c[0] ? 10'd8 : 10'd16, a);
		end
		$display("test clear source done");
		final_report();
	end
endmodule : tb_top
